// *** logic/prt_pkg.sv ***
package prt_pkg;

// Overview of operation
// - Every peripheral register sits behind its own peripheral address.
// - Peripheral read copies the addressed register into the holding buffer.
// - Peripheral write loads the holding buffer into the addressed register.
// - Each register is read-write, write-only or read-only.
// - Reading a write-only register returns an undefined value.
// - Writing a read-only register leaves it unchanged.
// - Every transfer is either 8 or 16 bits wide.
// - Reads and writes of either width complete in one instruction time.
// - Surplus register bits are ignored on write, zero or undefined on read.
// - An 8-bit write ignores the upper byte of the holding buffer.
// - An 8-bit read leaves the holding buffer upper byte unchanged.
// - Per register, surplus read bits are always zero or always undefined.
// - Unmapped address reads undefined and writes change nothing.

  localparam int PRT_DATA_W = 16;
  localparam int PRT_ADDR_W = 7;
  localparam int PRT_BYTE_W = 8;
  localparam int PRT_NIB_W = 4;
  localparam int PRT_NUM_REGS = 4;

  typedef logic [PRT_DATA_W-1:0] prt_word_t;
  typedef logic [PRT_ADDR_W-1:0] prt_addr_t;

  localparam prt_word_t PRT_BYTE_MASK = 16'h00ff;
  localparam prt_word_t PRT_WORD_MASK = 16'hffff;
  localparam prt_word_t PRT_ZERO_WORD = 16'h0000;
  // Arbitrary stand-in pattern for undefined read data
  localparam prt_word_t PRT_UNDEF_FILL = 16'h5a5a;

  typedef enum logic [1:0] {
    PRT_ACC_RW = 2'h0,
    PRT_ACC_WO = 2'h1,
    PRT_ACC_RO = 2'h3
  } prt_access_e;

  typedef struct packed {
    prt_addr_t addr;
    prt_access_e access;
    prt_word_t valid_mask;
    logic surplus_zero;
    prt_word_t rst_value;
  } prt_reg_cfg_s;

  typedef struct packed {
    logic valid;
    logic peripheral_read_op;
    logic peripheral_write_op;
    logic wide;
    prt_addr_t addr;
  } prt_op_s;

  typedef struct packed {
    logic unmapped;
    logic class_violation;
    logic bad_op;
  } prt_status_s;

  typedef struct packed {
    logic was_write;
    logic wide;
    prt_addr_t addr;
  } prt_xfer_s;

  localparam prt_reg_cfg_s PRT_REG_TABLE [PRT_NUM_REGS] = '{
    '{addr: 7'h02, access: PRT_ACC_RW, valid_mask: 16'h007e,
      surplus_zero: 1'b1, rst_value: 16'h0000},
    '{addr: 7'h03, access: PRT_ACC_RW, valid_mask: 16'h00ff,
      surplus_zero: 1'b0, rst_value: 16'h0000},
    '{addr: 7'h10, access: PRT_ACC_WO, valid_mask: 16'hffff,
      surplus_zero: 1'b0, rst_value: 16'h0000},
    '{addr: 7'h11, access: PRT_ACC_RO, valid_mask: 16'h0fff,
      surplus_zero: 1'b1, rst_value: 16'h0000}
  };

endpackage

// *** logic/prt_slot.sv ***
`timescale 1ns/1ns
module prt_slot #(
  parameter prt_pkg::prt_reg_cfg_s CFG = '0,
  parameter prt_pkg::prt_word_t UNDEF_FILL = prt_pkg::PRT_UNDEF_FILL
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic wr_en,
  input wire prt_pkg::prt_word_t wr_mask,
  input wire prt_pkg::prt_word_t wr_data,
  input wire prt_pkg::prt_word_t hw_data,
  output prt_pkg::prt_word_t value_q,
  output prt_pkg::prt_word_t rd_data
);

  prt_pkg::prt_word_t keep_mask;
  prt_pkg::prt_word_t raw;
  prt_pkg::prt_word_t fill;

  // Only valid bits inside the transfer width may change
  assign keep_mask = wr_mask & CFG.valid_mask;

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      value_q <= CFG.rst_value & CFG.valid_mask;
    end
    else if (wr_en && (CFG.access != prt_pkg::PRT_ACC_RO))
    begin
      value_q <= (value_q & ~keep_mask) | (wr_data & keep_mask);
    end
  end

  always_comb
  begin
    case (CFG.access)
      prt_pkg::PRT_ACC_RW: raw = value_q;
      prt_pkg::PRT_ACC_RO: raw = hw_data;
      default: raw = UNDEF_FILL;
    endcase
    fill = CFG.surplus_zero ? prt_pkg::PRT_ZERO_WORD : UNDEF_FILL;
    rd_data = (raw & CFG.valid_mask) | (fill & ~CFG.valid_mask);
  end

endmodule

// *** logic/prt_top.sv ***
`timescale 1ns/1ns
module prt_top #(
  parameter int NUM_REGS = prt_pkg::PRT_NUM_REGS,
  parameter prt_pkg::prt_reg_cfg_s REG_TABLE [NUM_REGS] =
    prt_pkg::PRT_REG_TABLE,
  parameter prt_pkg::prt_word_t UNDEF_FILL = prt_pkg::PRT_UNDEF_FILL
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire prt_pkg::prt_op_s op_req,
  input wire logic buf_load,
  input wire prt_pkg::prt_word_t buf_load_data,
  input wire logic [NUM_REGS-1:0][prt_pkg::PRT_DATA_W-1:0] periph_hw_data,
  output prt_pkg::prt_word_t holding_buffer,
  output logic [prt_pkg::PRT_NIB_W-1:0] holding_nibble_top,
  output logic [prt_pkg::PRT_NIB_W-1:0] holding_nibble_upper_mid,
  output logic op_done,
  output prt_pkg::prt_status_s op_status,
  output prt_pkg::prt_xfer_s last_xfer,
  output logic [NUM_REGS-1:0][prt_pkg::PRT_DATA_W-1:0] periph_reg_value,
  output logic [NUM_REGS-1:0] periph_wr_strobe,
  output logic [NUM_REGS-1:0] periph_rd_strobe
);

  localparam int NIB3_LO = 3 * prt_pkg::PRT_NIB_W;
  localparam int NIB2_LO = 2 * prt_pkg::PRT_NIB_W;

  prt_pkg::prt_word_t holding_buffer_q;
  prt_pkg::prt_word_t holding_buffer_d;
  logic op_done_q;
  prt_pkg::prt_status_s op_status_q;
  prt_pkg::prt_status_s op_status_d;
  prt_pkg::prt_xfer_s last_xfer_q;
  logic [NUM_REGS-1:0] wr_strobe_q;
  logic [NUM_REGS-1:0] rd_strobe_q;

  logic op_read;
  logic op_write;
  logic op_bad;
  prt_pkg::prt_word_t xfer_mask;
  logic [NUM_REGS-1:0] hit;
  logic [NUM_REGS-1:0] wr_en;
  logic [NUM_REGS-1:0] rd_en;
  logic [NUM_REGS-1:0] violation;
  prt_pkg::prt_word_t slot_rd [NUM_REGS];
  prt_pkg::prt_word_t rd_word;
  logic any_hit;
  logic any_violation;

  // Exactly one of the two operations must be requested
  assign op_read = op_req.valid && op_req.peripheral_read_op &&
                   !op_req.peripheral_write_op;
  assign op_write = op_req.valid && op_req.peripheral_write_op &&
                    !op_req.peripheral_read_op;
  assign op_bad = op_req.valid && (op_req.peripheral_read_op ==
                                   op_req.peripheral_write_op);

  // Narrow transfers touch only the low byte
  assign xfer_mask = op_req.wide ? prt_pkg::PRT_WORD_MASK
                                 : prt_pkg::PRT_BYTE_MASK;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++)
    begin : g_reg
      assign hit[gi] = (op_read || op_write) &&
                       (op_req.addr == REG_TABLE[gi].addr);
      assign wr_en[gi] = op_write && hit[gi];
      assign rd_en[gi] = op_read && hit[gi] &&
                         (REG_TABLE[gi].access != prt_pkg::PRT_ACC_WO);
      // Flags accesses outside the register's class
      assign violation[gi] = hit[gi] &&
        ((op_read && (REG_TABLE[gi].access == prt_pkg::PRT_ACC_WO)) ||
         (op_write && (REG_TABLE[gi].access == prt_pkg::PRT_ACC_RO)));

      prt_slot #(
        .CFG(REG_TABLE[gi]),
        .UNDEF_FILL(UNDEF_FILL)
      ) u_slot (
        .clk(clk),
        .sys_rst(sys_rst),
        .wr_en(wr_en[gi]),
        .wr_mask(xfer_mask),
        .wr_data(holding_buffer_q),
        .hw_data(periph_hw_data[gi]),
        .value_q(periph_reg_value[gi]),
        .rd_data(slot_rd[gi])
      );
    end
  endgenerate

  // Duplicate addresses in the table: highest index wins
  always_comb
  begin
    rd_word = UNDEF_FILL;
    any_hit = 1'b0;
    for (int i = 0; i < NUM_REGS; i++)
    begin
      if (hit[i])
      begin
        rd_word = slot_rd[i];
        any_hit = 1'b1;
      end
    end
    any_violation = |violation;
  end

  always_comb
  begin
    holding_buffer_d = holding_buffer_q;
    if (op_read)
    begin
      if (op_req.wide)
      begin
        holding_buffer_d = rd_word;
      end
      else
      begin
        holding_buffer_d = {
          holding_buffer_q[prt_pkg::PRT_DATA_W-1:prt_pkg::PRT_BYTE_W],
          rd_word[prt_pkg::PRT_BYTE_W-1:0]};
      end
    end
    else if (buf_load)
    begin
      // CPU loads lose to a same-cycle read, which also fills the buffer
      holding_buffer_d = buf_load_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      holding_buffer_q <= prt_pkg::PRT_ZERO_WORD;
    end
    else
    begin
      holding_buffer_q <= holding_buffer_d;
    end
  end

  // Every accepted operation finishes at the next edge
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      op_done_q <= 1'b0;
    end
    else
    begin
      op_done_q <= op_read || op_write || op_bad;
    end
  end

  always_comb
  begin
    op_status_d = op_status_q;
    if (op_req.valid)
    begin
      op_status_d.unmapped = (op_read || op_write) && !any_hit;
      op_status_d.class_violation = any_violation;
      op_status_d.bad_op = op_bad;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      op_status_q <= '0;
    end
    else
    begin
      op_status_q <= op_status_d;
    end
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      last_xfer_q <= '0;
    end
    else if (op_read || op_write)
    begin
      last_xfer_q.was_write <= op_write;
      last_xfer_q.wide <= op_req.wide;
      last_xfer_q.addr <= op_req.addr;
    end
  end

  // Strobes let peripherals react to an access, e.g. clear on read
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wr_strobe_q <= '0;
      rd_strobe_q <= '0;
    end
    else
    begin
      for (int i = 0; i < NUM_REGS; i++)
      begin
        wr_strobe_q[i] <= wr_en[i] &&
          (REG_TABLE[i].access != prt_pkg::PRT_ACC_RO);
      end
      rd_strobe_q <= rd_en;
    end
  end

  assign holding_buffer = holding_buffer_q;
  assign holding_nibble_top = holding_buffer_q[NIB3_LO +: prt_pkg::PRT_NIB_W];
  assign holding_nibble_upper_mid =
    holding_buffer_q[NIB2_LO +: prt_pkg::PRT_NIB_W];
  assign op_done = op_done_q;
  assign op_status = op_status_q;
  assign last_xfer = last_xfer_q;
  assign periph_wr_strobe = wr_strobe_q;
  assign periph_rd_strobe = rd_strobe_q;

endmodule

// *** verif/prt_monitor.sv ***
`timescale 1ns/1ns
module prt_monitor #(
  parameter int NUM_REGS = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire prt_pkg::prt_op_s op_req,
  input wire prt_pkg::prt_word_t holding_buffer,
  input wire logic [3:0] holding_nibble_top,
  input wire logic [3:0] holding_nibble_upper_mid,
  input wire logic op_done,
  input wire logic [NUM_REGS-1:0][15:0] periph_reg_value,
  input wire logic [NUM_REGS-1:0] periph_rd_strobe
);
  logic rd;
  logic wr;
  assign rd = op_req.valid & op_req.peripheral_read_op &
    !op_req.peripheral_write_op;
  assign wr = op_req.valid & op_req.peripheral_write_op &
    !op_req.peripheral_read_op;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_rd(a, w);
    rd && op_req.addr == a && op_req.wide == w;
  endsequence
  sequence s_wr(a);
    wr && op_req.addr == a;
  endsequence
  AST_DONE: assert property (op_req.valid |=> op_done)
    else $error("op not done");
  AST_IDLE: assert property (!op_req.valid |=> !op_done)
    else $error("stray done");
  AST_NIB_TOP: assert property (
    holding_nibble_top == holding_buffer[15:12])
    else $error("top nibble");
  AST_NIB_MID: assert property (
    holding_nibble_upper_mid == holding_buffer[11:8])
    else $error("mid nibble");
  AST_RD8_KEEP: assert property ((rd && !op_req.wide) |=>
    holding_buffer[15:8] == $past(holding_buffer[15:8]))
    else $error("upper byte moved");
  AST_WO_READ: assert property (s_rd(7'h10, 1'b1) |=>
    holding_buffer == prt_pkg::PRT_UNDEF_FILL && !periph_rd_strobe[2])
    else $error("write-only read");
  AST_RO_KEEP: assert property (s_wr(7'h11) |=>
    $stable(periph_reg_value[3]))
    else $error("read-only changed");
  AST_WR8: assert property (s_wr(7'h03) ##0 !op_req.wide |=>
    periph_reg_value[1] == {8'h00, $past(holding_buffer[7:0])})
    else $error("byte write");
  AST_UNMAP: assert property ((wr &&
    !(op_req.addr inside {7'h02, 7'h03, 7'h10, 7'h11})) |=>
    $stable(periph_reg_value))
    else $error("unmapped write");
  AST_RD_RW: assert property (s_rd(7'h02, 1'b1) |=>
    holding_buffer == $past(periph_reg_value[0]))
    else $error("read data");
endmodule
bind prt_top prt_monitor #(.NUM_REGS(NUM_REGS)) prt_monitor_i (.clk,
  .sys_rst, .op_req, .holding_buffer, .holding_nibble_top,
  .holding_nibble_upper_mid, .op_done, .periph_reg_value,
  .periph_rd_strobe);

// *** verif/prt_periph.sv ***
`timescale 1ns/1ns
module prt_periph #(
  parameter int NUM_REGS = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  output logic [NUM_REGS-1:0][15:0] hw_data
);
  logic [15:0] cnt_q;
  // Live value moves every cycle so a stale sample shows up
  always_ff @(posedge clk)
    if (sys_rst)
      cnt_q <= 16'h0c35;
    else
      cnt_q <= cnt_q + 16'h1357;
  assign hw_data = {NUM_REGS{cnt_q}};
endmodule

// *** verif/tb.sv ***
`timescale 1ns/1ns
module tb;
  logic clk = 0;
  logic sys_rst = 1;
  prt_pkg::prt_op_s op_req = '0;
  logic buf_load = 0;
  prt_pkg::prt_word_t buf_load_data = '0;
  prt_pkg::prt_word_t hb;
  logic [3:0][15:0] hw, regs, snap, hws;
  logic done;
  prt_pkg::prt_status_s st;
  prt_pkg::prt_xfer_s lx;
  logic [3:0] wrs, rds;
  int bad_count = 0;
  int total_checks = 0;
  int cyc = 0;
  always #5 clk = ~clk;
  prt_periph prt_periph_i (.clk, .sys_rst, .hw_data(hw));
  prt_top prt_top_i (.clk, .sys_rst, .op_req, .buf_load, .buf_load_data,
    .periph_hw_data(hw), .holding_buffer(hb), .holding_nibble_top(),
    .holding_nibble_upper_mid(), .op_done(done), .op_status(st),
    .last_xfer(lx), .periph_reg_value(regs), .periph_wr_strobe(wrs),
    .periph_rd_strobe(rds));
  task automatic chk(input logic [63:0] g, e);
    total_checks++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic op(input logic r, w, wd, input prt_pkg::prt_addr_t a);
    @(negedge clk);
    op_req = '{1'b1, r, w, wd, a};
    snap = regs;
    hws = hw;
    @(negedge clk);
    op_req = '0;
    chk(done, 1'b1);
  endtask
  task automatic ld(input prt_pkg::prt_word_t d);
    @(negedge clk);
    buf_load = 1;
    buf_load_data = d;
    @(negedge clk);
    buf_load = 0;
    chk(hb, d);
  endtask
  task automatic t_rw;
    ld(16'hffff);
    op(0, 1, 1, 7'h02);
    chk(regs[0], 16'h007e);
    ld(16'h0000);
    op(1, 0, 1, 7'h02);
    chk(hb, 16'h007e);
  endtask
  task automatic t_byte;
    ld(16'hab12);
    op(0, 1, 0, 7'h03);
    chk(regs[1], 16'h0012);
    ld(16'hcd00);
    op(1, 0, 0, 7'h03);
    chk(hb, 16'hcd12);
    op(1, 0, 1, 7'h03);
    chk(hb, {prt_pkg::PRT_UNDEF_FILL[15:8], 8'h12});
  endtask
  task automatic t_wo;
    ld(16'h1234);
    op(0, 1, 1, 7'h10);
    chk(regs[2], 16'h1234);
    op(1, 0, 1, 7'h10);
    chk(hb, prt_pkg::PRT_UNDEF_FILL);
  endtask
  task automatic t_ro;
    ld(16'hffff);
    op(0, 1, 1, 7'h11);
    chk(regs[3], snap[3]);
    op(1, 0, 1, 7'h11);
    chk(hb, hws[3] & 16'h0fff);
  endtask
  task automatic t_unmapped;
    ld(16'h1111);
    op(0, 1, 1, 7'h55);
    chk(regs, snap);
    op(1, 0, 0, 7'h55);
    chk(hb, {8'h11, prt_pkg::PRT_UNDEF_FILL[7:0]});
  endtask
  // Strobes, status and last transfer, plus a bad op and a load clash
  task automatic t_flags;
    ld(16'h00a5);
    op(0, 1, 0, 7'h03);
    chk({wrs, rds, st, lx}, {4'h2, 4'h0, 3'h0, 1'b1, 1'b0, 7'h03});
    @(negedge clk);
    chk({wrs, rds, done}, 9'h000);
    op(1, 0, 0, 7'h02);
    chk({rds, hb}, {4'h1, 16'h007e});
    op(1, 0, 1, 7'h10);
    chk({rds, st}, {4'h0, 3'h2});
    op(0, 1, 1, 7'h11);
    chk({wrs, st}, {4'h0, 3'h2});
    op(1, 0, 1, 7'h55);
    chk({st, hb}, {3'h4, prt_pkg::PRT_UNDEF_FILL});
    op(1, 1, 1, 7'h02);
    chk({st, lx}, {3'h1, 1'b0, 1'b1, 7'h55});
    chk(hb, prt_pkg::PRT_UNDEF_FILL);
    @(negedge clk);
    buf_load = 1;
    buf_load_data = 16'hbeef;
    op_req = '{1'b1, 1'b1, 1'b0, 1'b0, 7'h03};
    @(negedge clk);
    buf_load = 0;
    op_req = '0;
    chk(hb, {prt_pkg::PRT_UNDEF_FILL[15:8], 8'ha5});
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 1000)
    begin
      bad_count++;
      tally_and_finish;
    end
  end
  initial
  begin
    repeat (10) @(negedge clk);
    sys_rst = 0;
    chk(hb, 16'h0000);
    t_rw;
    t_byte;
    t_wo;
    t_ro;
    t_unmapped;
    t_flags;
    tally_and_finish;
  end
endmodule
